/* limit_status_params.svh */
/*
 * Constants for the limit status and sampling configuration block:
 * register offsets, writable masks, reset values, field positions and
 * sampling times.
 * Assumes the includer is compiled with a 50 MHz clock.
 */
// Behaviour
// R01 - Sticky under-limit flags on bits 7, 6, 0
// R02 - Summary under-limit bit follows any flag
// R03 - Read clears flags; summary clears once healthy
// R04 - Under-limit flags hold until read
// R05 - Alert on unmasked flag after queue count
// R06 - Critical flags set at or above limit
// R07 - Reading critical flags never clears them
// R08 - Critical flag self-clears below limit minus hysteresis
// R09 - Critical summary clears when all flags clear
// R10 - Critical output low while any flag set
// R11 - Bit 7 routes spikes to alert or critical
// R12 - Spike alert only in comparator mode
// R13 - Supply queue depth 1 to 4 at bits 3-2
// R14 - Supply averaging select at bits 1-0
// R15 - Shunt queue depth 1 to 4 at bits 7-6
// R16 - Shunt averaging select at bits 5-4
// R17 - Shunt sampling time select at bits 3-2
// R18 - Shunt result refreshed per time times averaging
// R19 - Shunt full-scale select at bits 1-0, reset 80 mV
// R20 - Peak mask blocks spike alert only
// R21 - Unused bits read zero, writes ignored
`ifndef LIMIT_STATUS_PARAMS_SVH
`define LIMIT_STATUS_PARAMS_SVH

// ==========================================================
// Register map
`define OFS_UNDER_FLAGS   8'h36
`define OFS_SEVERE_FLAGS  8'h37
`define OFS_SUPPLY_CFG    8'h50
`define OFS_SHUNT_CFG     8'h51

// ==========================================================
// Reset values and writable masks
`define RST_FLAGS         8'h00
`define RST_SUPPLY_CFG    8'h80
`define RST_SHUNT_CFG     8'h03
`define WMASK_SUPPLY_CFG  8'h8F
`define WMASK_SHUNT_CFG   8'hFF
`define FLAG_MASK         8'hC1

// ==========================================================
// Flag bit positions (channel order shunt, supply, diode)
`define BIT_SHUNT         7
`define BIT_SUPPLY        6
`define BIT_DIODE         0

// ==========================================================
// Configuration field positions
`define BIT_SPIKE_ROUTE   7
`define SUP_QUEUE_LSB     2
`define SUP_FILTER_LSB    0
`define SHU_QUEUE_LSB     6
`define SHU_FILTER_LSB    4
`define SHU_PERIOD_LSB    2
`define SHU_RANGE_LSB     0

// ==========================================================
// Timing
`define CLK_KHZ           50000
`define SHUNT_BASE_MS     82
`define SHUNT_BASE_CYC    (`SHUNT_BASE_MS * `CLK_KHZ)

`endif

/* limit_status_pkg.sv */
/*
 * Types shared by the limit status block and its queue counters.
 * Assumes limit_status_params.svh is available on the include path.
 */
`default_nettype none
package limit_status_pkg;
   typedef logic [7:0] reg_byte_t;   // One register byte
   typedef logic [1:0] sel2_t;       // Two-bit select field
   typedef logic [2:0] chan_vec_t;   // Per channel: 2 shunt,1 supply,0 diode
   typedef logic [2:0] qcount_t;     // Consecutive sample count
endpackage
`default_nettype wire

/* queue_if.sv */
/*
 * Link between the status block and one consecutive-sample counter.
 * Assumes both ends share the single block clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface queue_if;
   import limit_status_pkg::*;
   logic  sampleDone;   // Channel finished a measurement
   logic  outOfLimit;   // That measurement was out of limit
   sel2_t depthSel;     // Queue depth select, 00 means one
   logic  reached;      // Count reached on this sample
   modport owner (output sampleDone, output outOfLimit,
                  output depthSel, input reached);
   modport counter (input sampleDone, input outOfLimit,
                    input depthSel, output reached);
endinterface
`default_nettype wire

/* queue_counter.sv */
/*
 * Counts consecutive out-of-limit measurements of one channel and
 * signals when the programmed depth is reached.
 * Assumes sample strobes are one-cycle pulses on the block clock.
 */
`timescale 1ns/1ns
`default_nettype none
module queue_counter (
   input  wire logic clk,
   input  wire logic rst_n,
   queue_if.counter  q
);
   import limit_status_pkg::*;

   // ==========================================================
   // Counter
   qcount_t count;        // Consecutive bad samples so far
   qcount_t next_count;   // Next count
   qcount_t bumped;       // Count including this sample

   // Saturate at four; deeper counts are meaningless
   always_comb begin
      bumped = (count == 3'h4) ? count : count + 3'h1;
      next_count = count;
      if (q.sampleDone) begin
         next_count = q.outOfLimit ? bumped : 3'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= 3'h0;
      end else begin
         count <= next_count;
      end
   end

   // Depth select 00..11 means 1..4 samples
   assign q.reached = q.sampleDone && q.outOfLimit &&
                      (bumped > {1'b0, q.depthSel});
endmodule
`default_nettype wire

/* limit_status.sv */
/*
 * Limit status flags, critical output, spike routing and sampling
 * configuration of a current, voltage and temperature monitor.
 * Assumes the bus protocol engine outside presents one-cycle read and
 * write strobes with an address, and that comparators outside report
 * each measurement against its low, critical and release thresholds.
 */
`timescale 1ns/1ns
`default_nettype none
`include "limit_status_params.svh"
module limit_status #(
   parameter int unsigned BASE_PERIOD_CYC = `SHUNT_BASE_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Register access from the bus protocol engine
   input  wire limit_status_pkg::reg_byte_t regAddr,
   input  wire limit_status_pkg::reg_byte_t regWrData,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   output logic [7:0]                    regRdData,
   // Per channel measurement results
   input  wire limit_status_pkg::chan_vec_t sampleDone,
   input  wire limit_status_pkg::chan_vec_t belowLow,
   input  wire limit_status_pkg::chan_vec_t atSevere,
   input  wire limit_status_pkg::chan_vec_t belowRelease,
   // Alert control from neighbouring registers
   input  wire limit_status_pkg::chan_vec_t chanMask,
   input  wire logic                     peakMask,
   input  wire logic                     alertComparator,
   input  wire logic                     spikeActive,
   // Status and pins
   output logic                          underSummary,
   output logic                          severeSummary,
   output logic                          alertOut_n,
   output logic                          overheat_out_n,
   // Configuration toward the converter
   output logic [1:0]                    supply_filter_sel,
   output logic [1:0]                    shunt_filter_sel,
   output logic [1:0]                    shunt_period_sel,
   output logic [1:0]                    shunt_fullscale_sel,
   output logic                          shuntRefresh
);
   import limit_status_pkg::*;

   // ==========================================================
   // Helpers
   // Spread a channel vector onto its flag bit positions
   function automatic reg_byte_t toFlags(input chan_vec_t v);
      reg_byte_t f;
      f = 8'h00;
      f[`BIT_SHUNT]  = v[2];
      f[`BIT_SUPPLY] = v[1];
      f[`BIT_DIODE]  = v[0];
      return f;
   endfunction

   // Averaging factor as a shift amount, 00 means one sample
   function automatic logic [2:0] avgShift(input sel2_t s);
      return {1'b0, s};
   endfunction

   // ==========================================================
   // Registers
   reg_byte_t underFlags;          // Sticky under-limit flags
   reg_byte_t severeFlags;         // Self-clearing critical flags
   reg_byte_t supplyCfg;           // Supply sampling configuration
   reg_byte_t shuntCfg;            // Shunt sampling configuration
   chan_vec_t lowNow;              // Last low comparison per channel
   reg_byte_t next_underFlags;
   reg_byte_t next_severeFlags;
   reg_byte_t next_supplyCfg;
   reg_byte_t next_shuntCfg;
   chan_vec_t next_lowNow;
   logic      next_underSummary;
   logic      next_severeSummary;
   logic      next_alertOut_n;
   logic      next_overheat_n;
   reg_byte_t next_rdData;
   chan_vec_t queueHit;            // Depth reached on this sample
   logic      readUnder;           // Read strobe on the sticky flags

   // ==========================================================
   // Queue counters, one per channel
   sel2_t depthOf [3];
   assign depthOf[2] = shuntCfg[`SHU_QUEUE_LSB +: 2];            // R15
   assign depthOf[1] = supplyCfg[`SUP_QUEUE_LSB +: 2];           // R13
   assign depthOf[0] = 2'h0;   // Diode queue depth fixed at one sample

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : gen_queue
         queue_if qi ();
         assign qi.sampleDone = sampleDone[gi];
         assign qi.outOfLimit = belowLow[gi];
         assign qi.depthSel   = depthOf[gi];
         assign queueHit[gi]  = qi.reached;
         queue_counter u_count (
            .clk   (clk),
            .rst_n (rst_n),
            .q     (qi)
         );
      end
   endgenerate

   // ==========================================================
   // Next state of status, configuration and pins
   always_comb begin
      readUnder = regRead && (regAddr == `OFS_UNDER_FLAGS);

      // Low condition as seen by the latest sample per channel
      next_lowNow = (lowNow & ~sampleDone) | (belowLow & sampleDone);

      // Read clears, but a new event in the same cycle wins
      next_underFlags = readUnder ? `RST_FLAGS : underFlags;       // R03 R04
      next_underFlags = next_underFlags | toFlags(queueHit);       // R01

      // Summary set by any flag, cleared only once healthy
      next_underSummary = underSummary;
      if (readUnder && (next_lowNow == 3'h0)) begin
         next_underSummary = 1'b0;                                 // R03
      end
      if (next_underFlags != 8'h00) begin
         next_underSummary = 1'b1;                                 // R02
      end

      // Critical flags: set at limit, clear below release point
      // A read of the critical register has no effect here
      next_severeFlags = severeFlags;                              // R07
      next_severeFlags = next_severeFlags &
                         ~toFlags(sampleDone & belowRelease);      // R08
      next_severeFlags = next_severeFlags |
                         toFlags(sampleDone & atSevere);           // R06
      next_severeSummary = (next_severeFlags != 8'h00);            // R06 R09

      // Configuration writes; unused bits never store
      next_supplyCfg = supplyCfg;
      next_shuntCfg  = shuntCfg;
      if (regWrite && (regAddr == `OFS_SUPPLY_CFG)) begin
         next_supplyCfg = regWrData & `WMASK_SUPPLY_CFG;           // R21
      end
      if (regWrite && (regAddr == `OFS_SHUNT_CFG)) begin
         next_shuntCfg = regWrData & `WMASK_SHUNT_CFG;
      end

      // Alert from unmasked sticky flags; spike only when routed here
      next_alertOut_n = ~((next_underFlags &
                           ~toFlags(chanMask)) != 8'h00);          // R05
      if (!supplyCfg[`BIT_SPIKE_ROUTE] && spikeActive &&
          !peakMask && alertComparator) begin                      // R11 R12 R20
         next_alertOut_n = 1'b0;
      end

      // Critical pin from any flag or a spike routed here, unmasked
      next_overheat_n = ~((next_severeFlags != 8'h00) ||
                          (supplyCfg[`BIT_SPIKE_ROUTE] &&
                           spikeActive));                          // R10 R11

      // Read data; unmapped addresses and unused bits read zero
      case (regAddr)
         `OFS_UNDER_FLAGS:  next_rdData = underFlags & `FLAG_MASK; // R21
         `OFS_SEVERE_FLAGS: next_rdData = severeFlags & `FLAG_MASK;
         `OFS_SUPPLY_CFG:   next_rdData = supplyCfg;
         `OFS_SHUNT_CFG:    next_rdData = shuntCfg;
         default:           next_rdData = 8'h00;
      endcase
      if (!regRead) begin
         next_rdData = regRdData;
      end
   end

   // Register everything; outputs come straight from flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         underFlags     <= `RST_FLAGS;
         severeFlags    <= `RST_FLAGS;
         supplyCfg      <= `RST_SUPPLY_CFG;
         shuntCfg       <= `RST_SHUNT_CFG;                         // R19
         lowNow         <= 3'h0;
         underSummary   <= 1'b0;
         severeSummary  <= 1'b0;
         alertOut_n     <= 1'b1;
         overheat_out_n <= 1'b1;
         regRdData      <= 8'h00;
      end else begin
         underFlags     <= next_underFlags;
         severeFlags    <= next_severeFlags;
         supplyCfg      <= next_supplyCfg;
         shuntCfg       <= next_shuntCfg;
         lowNow         <= next_lowNow;
         underSummary   <= next_underSummary;
         severeSummary  <= next_severeSummary;
         alertOut_n     <= next_alertOut_n;
         overheat_out_n <= next_overheat_n;
         regRdData      <= next_rdData;
      end
   end

   // ==========================================================
   // Configuration fields toward the converter
   always_comb begin
      supply_filter_sel   = supplyCfg[`SUP_FILTER_LSB +: 2];       // R14
      shunt_filter_sel    = shuntCfg[`SHU_FILTER_LSB +: 2];        // R16
      shunt_period_sel    = shuntCfg[`SHU_PERIOD_LSB +: 2];        // R17
      shunt_fullscale_sel = shuntCfg[`SHU_RANGE_LSB +: 2];         // R19
   end

   // ==========================================================
   // Shunt refresh timer
   // The base period is counted once, then repeated a number of
   // times set by period and averaging; this keeps one wide counter
   // instead of a table of long totals.
   localparam int unsigned BASE_W = $clog2(BASE_PERIOD_CYC + 1);
   logic [BASE_W-1:0] baseCnt;       // Cycles within one base period
   logic [BASE_W-1:0] next_baseCnt;
   logic [5:0]        repCnt;        // Base periods elapsed
   logic [5:0]        next_repCnt;
   logic [5:0]        repTotal;      // Base periods per refresh
   logic [2:0]        periodShift;   // Sampling time as a shift
   logic              next_refresh;

   always_comb begin
      // 00 and 01 both give the base time, 10 double, 11 four times
      case (shunt_period_sel)
         2'h2:    periodShift = 3'h1;                              // R17
         2'h3:    periodShift = 3'h2;
         default: periodShift = 3'h0;
      endcase
      repTotal = 6'h01 << (periodShift + avgShift(shunt_filter_sel)); // R18
      next_baseCnt = baseCnt + 1'b1;
      next_repCnt  = repCnt;
      next_refresh = 1'b0;
      if (baseCnt == BASE_W'(BASE_PERIOD_CYC - 1)) begin
         next_baseCnt = '0;
         next_repCnt  = repCnt + 6'h01;
         if (repCnt + 6'h01 >= repTotal) begin
            next_repCnt  = 6'h00;
            next_refresh = 1'b1;                                   // R18
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         baseCnt      <= '0;
         repCnt       <= 6'h00;
         shuntRefresh <= 1'b0;
      end else begin
         baseCnt      <= next_baseCnt;
         repCnt       <= next_repCnt;
         shuntRefresh <= next_refresh;
      end
   end
endmodule
`default_nettype wire

/* smbus_host_model.sv */
/*
 * Register host model: byte reads and writes on the strobe port.
 * Assumes one block clock; requests change at its falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module smbus_host_model
   import limit_status_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] regRdData,
   output reg_byte_t       regAddr,
   output reg_byte_t       regWrData,
   output logic            regWrite,
   output logic            regRead
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // One write strobe; released data is inverted, never left stale
   task automatic wr(input reg_byte_t a, input reg_byte_t d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      regWrData = ~d;
   endtask
   // One read strobe; data is registered, taken a cycle later
   task automatic rd(input reg_byte_t a, output reg_byte_t d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      d = regRdData;
   endtask
endmodule
`default_nettype wire

/* limit_status_sva.sv */
/*
 * Checker for the limit status block, bound to its top ports.
 * Assumes the short refresh base of eight cycles or more.
 */
`timescale 1ns/1ns
`default_nettype none
module limit_status_sva
   import limit_status_pkg::*;
#(
   parameter int unsigned BASE_PERIOD_CYC = 8
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire reg_byte_t  regAddr,
   input wire reg_byte_t  regWrData,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdData,
   input wire chan_vec_t  sampleDone,
   input wire chan_vec_t  belowLow,
   input wire chan_vec_t  atSevere,
   input wire chan_vec_t  belowRelease,
   input wire logic       underSummary,
   input wire logic       severeSummary,
   input wire logic       overheat_out_n,
   input wire logic [1:0] supply_filter_sel,
   input wire logic [1:0] shunt_filter_sel,
   input wire logic [1:0] shunt_period_sel,
   input wire logic [1:0] shunt_fullscale_sel,
   input wire logic       shuntRefresh
);
   // ==========================================================
   // Single domain, so one clock and one disable for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_diode_under: assert property (
      sampleDone[0] && belowLow[0] |=> underSummary)
      else $error("diode low sample left summary clear");
   a_under_hold: assert property (
      underSummary && !(regRead && regAddr == 8'h36) |=> underSummary)
      else $error("under summary dropped without a read");
   a_severe_set: assert property (
      |(sampleDone & atSevere) |=> severeSummary && !overheat_out_n)
      else $error("critical sample not flagged");
   a_severe_hold: assert property (
      severeSummary && !(|(sampleDone & belowRelease)) |=> severeSummary)
      else $error("critical summary cleared without release");
   a_severe_pin: assert property (
      severeSummary |-> !overheat_out_n)
      else $error("critical pin high while flagged");
   a_supply_cfg: assert property (
      regWrite && regAddr == 8'h50 |=>
      {6'h00, supply_filter_sel} == ($past(regWrData) & 8'h03))
      else $error("supply averaging select not stored");
   a_shunt_cfg: assert property (
      regWrite && regAddr == 8'h51 |=>
      {2'b00, shunt_filter_sel, shunt_period_sel, shunt_fullscale_sel}
      == ($past(regWrData) & 8'h3F))
      else $error("shunt selects not stored");
   a_unused_zero: assert property (
      regRead && !(regAddr inside {8'h36, 8'h37, 8'h50, 8'h51}) |=>
      regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_refresh_gap: assert property (
      shuntRefresh |=> !shuntRefresh [*7])
      else $error("refresh pulses too close");
endmodule
bind limit_status limit_status_sva #(.BASE_PERIOD_CYC(BASE_PERIOD_CYC)) sva (
   .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .sampleDone(sampleDone), .belowLow(belowLow), .atSevere(atSevere),
   .belowRelease(belowRelease), .underSummary(underSummary),
   .severeSummary(severeSummary), .overheat_out_n(overheat_out_n),
   .supply_filter_sel(supply_filter_sel), .shunt_filter_sel(shunt_filter_sel),
   .shunt_period_sel(shunt_period_sel),
   .shunt_fullscale_sel(shunt_fullscale_sel), .shuntRefresh(shuntRefresh));
`default_nettype wire

/* test_limit_status.sv */
/*
 * Self-checking bench for the limit status block against a model.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module test_limit_status;
   import limit_status_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, peakMask = 1'b0;
   logic alertComparator = 1'b0, spikeActive = 1'b0;
   chan_vec_t sampleDone = 3'h0, belowLow = 3'h0, atSevere = 3'h0;
   chan_vec_t belowRelease = 3'h0, chanMask = 3'h0, lastLow = 3'h0;
   reg_byte_t regAddr, regWrData, rd;
   logic regWrite, regRead, underSummary, severeSummary, alertOut_n;
   logic overheat_out_n, shuntRefresh;
   logic [7:0] regRdData;
   logic [1:0] supFil, shuFil, shuPer, shuRng;
   // Model state: flags, summary, configuration and queue counts
   int n_errors = 0, samples_checked = 0, under = 0, sev = 0, uSum = 0;
   int cfgSup = 'h80, cfgShu = 'h03, v, n, cnt[3] = '{0, 0, 0};
   // ==========================================================
   // Clock, host partner and design
   initial forever #10 clk = ~clk;
   smbus_host_model host (.clk(clk), .regRdData(regRdData),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead));
   limit_status #(.BASE_PERIOD_CYC(8)) dut (.clk(clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .sampleDone(sampleDone),
      .belowLow(belowLow), .atSevere(atSevere), .belowRelease(belowRelease),
      .chanMask(chanMask), .peakMask(peakMask), .spikeActive(spikeActive),
      .alertComparator(alertComparator), .underSummary(underSummary),
      .severeSummary(severeSummary), .alertOut_n(alertOut_n),
      .overheat_out_n(overheat_out_n), .supply_filter_sel(supFil),
      .shunt_filter_sel(shuFil), .shunt_period_sel(shuPer),
      .shunt_fullscale_sel(shuRng), .shuntRefresh(shuntRefresh));
   // ==========================================================
   // Compare tasks and verdict
   task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: read %h, model %h", $time, got, exp);
      end
   endtask
   task automatic chkOut(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: port %h, model %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Register read against the model
   task automatic rdChk(input reg_byte_t a, input int exp);
      host.rd(a, rd);
      chkReg(rd, exp[7:0]);
   endtask
   // Low flag register read: clears flags, summary only if healthy
   task automatic rdUnder;
      rdChk(8'h36, under);
      under = 0;
      if (lastLow == 3'h0) uSum = 0;
      chkOut(underSummary, uSum);
   endtask
   // One measurement strobe on channel ch, then compare all status pins
   task automatic meas(input int ch, input logic lo, sv, rl);
      int bm, dep, msk;
      bm = (ch == 2) ? 'h80 : (ch == 1) ? 'h40 : 'h01;
      // Channel masks spread onto their flag bit positions
      msk = {chanMask[2], chanMask[1], 5'h00, chanMask[0]};
      dep = (ch == 0) ? 1 : (ch == 1) ? cfgSup[3:2] + 1 : cfgShu[7:6] + 1;
      @(negedge clk);
      sampleDone[ch] = 1'b1;
      belowLow[ch] = lo;
      atSevere[ch] = sv;
      belowRelease[ch] = rl;
      @(negedge clk);
      {sampleDone, belowLow, atSevere, belowRelease} = '0;
      // Queue saturates at four and restarts on an in-limit sample
      cnt[ch] = lo ? ((cnt[ch] < 4) ? cnt[ch] + 1 : 4) : 0;
      if (lo && cnt[ch] >= dep) begin
         under |= bm;
         uSum = 1;
      end
      lastLow[ch] = lo;
      if (sv) sev |= bm;
      else if (rl) sev &= ~bm;
      chkOut(underSummary, uSum);
      chkOut(alertOut_n, (under & ~msk) == 0);
      chkOut(severeSummary, sev != 0);
      chkOut(overheat_out_n, sev == 0);
      if (sev != 0) rdChk(8'h37, sev);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(16469));
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      rdChk(8'h50, 'h80);
      rdChk(8'h51, 'h03);
      chkOut(shuRng, 3);
      rdChk(8'h40, 0);
      // Random configuration with reserved bits and read-only places
      repeat (4) begin
         v = $urandom;
         host.wr(8'h50, v[7:0]);
         cfgSup = v & 'h8F;
         host.wr(8'h51, v[15:8]);
         cfgShu = v[15:8];
         // Odd addresses below 40h never reach a writable register
         host.wr((v[23:16] & 8'h3F) | 8'h01, 8'hFF);
         rdChk(8'h50, cfgSup);
         rdChk(8'h51, cfgShu);
         chkOut({supFil, shuFil, shuPer, shuRng},
                {cfgSup[1:0], cfgShu[5:0]});
      end
      rdChk(8'h36, 0);
      // Queue depths of supply and shunt, interrupted run first
      for (int ch = 1; ch < 3; ch++) begin
         for (int d = 0; d < 4; d++) begin
            chanMask = 3'($urandom);
            cfgSup = 'h80 | (d << 2);
            cfgShu = (d << 6) | 'h03;
            host.wr(8'h50, cfgSup[7:0]);
            host.wr(8'h51, cfgShu[7:0]);
            meas(ch, 1, 0, 0);
            meas(ch, 0, 0, 0);
            for (int k = 0; k <= d; k++) meas(ch, 1, 0, 0);
            meas(0, 1, 0, 0);
            rdUnder();
            meas(ch, 0, 0, 0);
            meas(0, 0, 0, 0);
            rdUnder();
         end
      end
      // Critical flags: set, read without clearing, release
      meas(0, 0, 1, 0);
      meas(1, 0, 1, 1);
      meas(2, 0, 1, 0);
      meas(0, 0, 0, 1);
      meas(2, 0, 0, 1);
      meas(1, 0, 0, 1);
      // Spike routing, mask and comparator mode
      spikeActive = 1'b1;
      repeat (2) @(negedge clk);
      chkOut({overheat_out_n, alertOut_n}, 2'b01);
      host.wr(8'h50, 8'h00);
      alertComparator = 1'b1;
      repeat (2) @(negedge clk);
      chkOut({overheat_out_n, alertOut_n}, 2'b10);
      peakMask = 1'b1;
      repeat (2) @(negedge clk);
      chkOut(alertOut_n, 1);
      {peakMask, alertComparator} = 2'b00;
      repeat (2) @(negedge clk);
      chkOut(alertOut_n, 1);
      spikeActive = 1'b0;
      // Refresh interval: base times period factor times averaging
      foreach (cnt[i]) begin
         v = (i == 0) ? 'h04 : (i == 1) ? 'h18 : 'h3C;
         host.wr(8'h51, v[7:0]);
         for (int p = 0; p < 3; p++) begin
            n = 0;
            do begin
               @(negedge clk);
               n++;
            end while (!shuntRefresh && n < 2000);
            if (n >= 2000) begin
               n_errors++;
               end_of_test();
            end
         end
         chkOut(n, (i == 0) ? 8 : (i == 1) ? 32 : 256);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
